/* rtl/cmpp_port_pins.v */
// Purpose: mux of port a lines 28..31 for the first fast serial channel
// Assumes: mode static while traffic runs; all inputs synchronous
// Notes:   oe_n low means the module drives the line
`timescale 1ns/1ps
`include "cmpp_consts.vh"

// Operation
// - master transmit enable only with valid data
// - slave cell available when cell fits
// - rts low requests; cts low accepts
// - start of cell with first byte
// - mii transmit error on request
// - master receive enable means sample next
// - slave presents data after receive enable
// - mii transmit enable held while sending
// - direct polling supports four phy devices
module cmpp_port_pins #(
  parameter PHY_NUM = `CMPP_PHY_NUM
) (
  input  wire                    clk_sys,      // system clock
  input  wire                    reset,        // async reset, active high
  input  wire [`CMPP_MODE_W-1:0] mode,         // protocol and role
  // engine side
  input  wire                    tx_valid,     // engine has a tx byte
  input  wire                    tx_first,     // byte is first of cell
  input  wire                    tx_error,     // engine flags tx error
  input  wire                    slv_can_take, // slave can take a cell
  input  wire                    rx_want,      // engine wants rx byte
  input  wire                    hdlc_tx_req,  // hdlc wants to send
  input  wire                    hdlc_cts_n,   // cts from far end
  input  wire [PHY_NUM-1:0]      phy_clav_hi,  // extra polled clav lines
  input  wire [`CMPP_PHY_SEL_W-1:0] phy_sel,   // polled phy index
  output reg                     tx_take_r,    // byte taken this cycle
  output reg                     peer_clav_r,  // far end can take cell
  output reg  [PHY_NUM-1:0]      phy_clav_r,   // clav per polled phy
  output reg                     rx_sample_r,  // rx data valid to sample
  output reg                     slv_tx_en_r,  // master drives tx valid
  output reg                     slv_rx_en_r,  // master asked for rx
  output reg                     mii_col_r,    // collision seen
  output reg                     mii_crs_r,    // carrier seen
  output reg                     hdlc_grant_r, // rts accepted
  // port a lines
  input  wire                    port_a_line_thirty_one_i,       // line thirty one in
  input  wire                    port_a_line_thirty_i,       // line thirty in
  input  wire                    port_a_line_twenty_nine_i,       // line twenty nine in
  input  wire                    port_a_line_twenty_eight_i,       // line twenty eight in
  output reg                     port_a_line_thirty_one_o_r,     // line thirty one out
  output reg                     port_a_line_thirty_o_r,     // line thirty out
  output reg                     port_a_line_twenty_nine_o_r,     // line twenty nine out
  output reg                     port_a_line_twenty_eight_o_r,     // line twenty eight out
  output reg                     port_a_line_thirty_one_oe_n_r,  // drive thirty one, low
  output reg                     port_a_line_thirty_oe_n_r,  // drive thirty, low
  output reg                     port_a_line_twenty_nine_oe_n_r,  // drive twenty nine, low
  output reg                     port_a_line_twenty_eight_oe_n_r   // drive twenty eight, low
);

  wire is_mst  = (mode == `CMPP_MODE_UT_MST) || (mode == `CMPP_MODE_UT_MPHY);
  wire is_slv  = (mode == `CMPP_MODE_UT_SLV);
  wire is_mii  = (mode == `CMPP_MODE_MII);
  wire is_hdlc = (mode == `CMPP_MODE_HDLC);
  wire is_mphy = (mode == `CMPP_MODE_UT_MPHY);

  wire rts_n;
  wire grant;

  // ----------------------------------------------------------------
  // hdlc handshake
  // ----------------------------------------------------------------
  cmpp_rts_ctl u_rts (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .enable     (is_hdlc),
    .tx_request (hdlc_tx_req),
    .cts_n      (hdlc_cts_n),
    .rts_n_r    (rts_n),
    .granted_r  (grant)
  );

  // ----------------------------------------------------------------
  // pin functions
  // ----------------------------------------------------------------
  reg             rx_en_d_r;
  wire [PHY_NUM-1:0] clav_all = {phy_clav_hi[PHY_NUM-1:1], port_a_line_thirty_i};
  wire            sel_clav = is_mphy ? clav_all[phy_sel] : port_a_line_thirty_i;
  wire            tx_go    = tx_valid && sel_clav;

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      port_a_line_thirty_one_o_r <= 1'b0;   port_a_line_thirty_one_oe_n_r <= 1'b1;
      port_a_line_thirty_o_r <= 1'b0;   port_a_line_thirty_oe_n_r <= 1'b1;
      port_a_line_twenty_nine_o_r <= 1'b0;   port_a_line_twenty_nine_oe_n_r <= 1'b1;
      port_a_line_twenty_eight_o_r <= 1'b0;   port_a_line_twenty_eight_oe_n_r <= 1'b1;
      tx_take_r <= 1'b0;  peer_clav_r <= 1'b0;
      phy_clav_r <= {PHY_NUM{1'b0}};
      rx_sample_r <= 1'b0; rx_en_d_r <= 1'b0;
      slv_tx_en_r <= 1'b0; slv_rx_en_r <= 1'b0;
      mii_col_r <= 1'b0;  mii_crs_r <= 1'b0;
      hdlc_grant_r <= 1'b0;
    end else begin
      // direction per mode; idle lines left undriven
      port_a_line_thirty_one_oe_n_r <= !(is_mst);
      port_a_line_thirty_oe_n_r <= !(is_slv || is_hdlc);
      port_a_line_twenty_nine_oe_n_r <= !(is_mst || is_mii);
      port_a_line_twenty_eight_oe_n_r <= !(is_mst || is_mii);
      port_a_line_thirty_one_o_r <= is_mst && tx_go;
      port_a_line_twenty_nine_o_r <= (is_mst && tx_go && tx_first) ||
                  (is_mii && tx_error);
      port_a_line_twenty_eight_o_r <= (is_mst && rx_want) ||
                  (is_mii && tx_valid);
      port_a_line_thirty_o_r <= is_hdlc ? rts_n :
                  (is_slv && slv_can_take);
      tx_take_r   <= (is_mst && tx_go) || (is_mii && tx_valid);
      peer_clav_r <= is_mst && sel_clav;
      phy_clav_r  <= is_mphy ? clav_all : {PHY_NUM{1'b0}};
      rx_en_d_r   <= (is_mst && rx_want) || (is_slv && port_a_line_twenty_eight_i);
      rx_sample_r <= rx_en_d_r;
      slv_tx_en_r <= is_slv && port_a_line_thirty_one_i;
      slv_rx_en_r <= is_slv && port_a_line_twenty_eight_i;
      mii_col_r   <= is_mii && port_a_line_thirty_one_i;
      mii_crs_r   <= is_mii && port_a_line_thirty_i;
      hdlc_grant_r <= grant;
    end
  end

endmodule

/* rtl/cmpp_consts.vh */
// Purpose: constants for the cell and mii port pin block
// Assumes: included by bare name
// Notes:   mode codes select the function of the four port lines
`ifndef CMPP_CONSTS_VH
`define CMPP_CONSTS_VH

`define CMPP_MODE_W        3
`define CMPP_MODE_GPIO     3'h0
`define CMPP_MODE_UT_MST   3'h1
`define CMPP_MODE_UT_SLV   3'h2
`define CMPP_MODE_UT_MPHY  3'h3
`define CMPP_MODE_MII      3'h4
`define CMPP_MODE_HDLC     3'h5

`define CMPP_PHY_NUM       4
`define CMPP_PHY_SEL_W     2

`define CMPP_ST_IDLE       2'h0
`define CMPP_ST_REQ        2'h1
`define CMPP_ST_GRANT      2'h2

`endif

/* rtl/cmpp_rts_ctl.v */
// Purpose: modem handshake for the hdlc mode on port a line thirty
// Assumes: cts sampled synchronously, active low
// Notes:   request is independent of data timing
`timescale 1ns/1ps
`include "cmpp_consts.vh"

module cmpp_rts_ctl (
  input  wire       clk_sys,    // system clock
  input  wire       reset,      // async reset, active high
  input  wire       enable,     // hdlc mode selected
  input  wire       tx_request, // transmitter wants to send
  input  wire       cts_n,      // clear to send from far end
  output reg        rts_n_r,    // request to send, active low
  output reg        granted_r   // request accepted
);

  reg [1:0] state_r;
  reg [1:0] state_nxt;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      `CMPP_ST_IDLE:  if (enable && tx_request) state_nxt = `CMPP_ST_REQ;
      `CMPP_ST_REQ: begin
        if (!enable || !tx_request) state_nxt = `CMPP_ST_IDLE;
        else if (!cts_n) state_nxt = `CMPP_ST_GRANT;
      end
      `CMPP_ST_GRANT: if (!enable || !tx_request) state_nxt = `CMPP_ST_IDLE;
      default: state_nxt = `CMPP_ST_IDLE;
    endcase
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r   <= `CMPP_ST_IDLE;
      rts_n_r   <= 1'b1;
      granted_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      rts_n_r   <= (state_nxt == `CMPP_ST_IDLE);
      granted_r <= (state_nxt == `CMPP_ST_GRANT) && !cts_n;
    end
  end

endmodule

/* verif/cmpp_port_pins_assertions.sv */
// Purpose: temporal checks on the port lines of cmpp_port_pins
// Assumes: bound to the top module
// Notes:   registered outputs follow the inputs of the last edge
`timescale 1ns/1ps
`include "cmpp_consts.vh"
module cmpp_chk #(parameter PHY_NUM = 4) (
  input wire clk_sys, reset,                          // clock, reset
  input wire [`CMPP_MODE_W-1:0] mode,                 // protocol
  input wire tx_valid, tx_first, tx_error, rx_want,   // engine
  input wire slv_can_take, hdlc_tx_req, port_a_line_thirty_one_i, port_a_line_thirty_i, // inputs
  input wire [PHY_NUM-1:0] phy_clav_hi, phy_clav_r,   // polled clav
  input wire port_a_line_thirty_one_o_r, port_a_line_thirty_o_r, port_a_line_twenty_nine_o_r, port_a_line_twenty_eight_o_r,  // line outs
  input wire port_a_line_thirty_oe_n_r, rx_sample_r, mii_col_r      // status
);
  localparam [2:0] MST = `CMPP_MODE_UT_MST, SLV = `CMPP_MODE_UT_SLV;
  localparam [2:0] MPH = `CMPP_MODE_UT_MPHY, MII = `CMPP_MODE_MII, HDL = `CMPP_MODE_HDLC;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  txen_data_a: assert property (
    port_a_line_thirty_one_o_r && $past(mode) == MST |-> $past(tx_valid)) else $error("txen without data");
  soc_first_a: assert property (
    port_a_line_twenty_nine_o_r && $past(mode) == MST |-> port_a_line_thirty_one_o_r && $past(tx_first)) else $error("soc misplaced");
  rxen_sample_a: assert property (
    $past(mode, 2) == MST && $past(mode) == MST |-> rx_sample_r == $past(rx_want, 2))
    else $error("rx sample timing");
  slave_clav_a: assert property (
    $past(mode) == SLV |-> port_a_line_thirty_o_r == $past(slv_can_take) && !port_a_line_thirty_oe_n_r) else $error("clav");
  mii_txen_a: assert property (
    $past(mode) == MII |-> port_a_line_twenty_eight_o_r == $past(tx_valid) && port_a_line_twenty_nine_o_r == $past(tx_error))
    else $error("mii tx lines");
  mii_col_a: assert property (
    mii_col_r |-> $past(mode) == MII && $past(port_a_line_thirty_one_i)) else $error("collision relay");
  poll_clav_a: assert property (
    $past(mode) == MPH |-> phy_clav_r[0] == $past(port_a_line_thirty_i)
    && phy_clav_r[3:1] == $past(phy_clav_hi[3:1])) else $error("polled clav");
  rts_req_a: assert property (
    $past(mode) == HDL && $past(mode, 2) == HDL && $past(hdlc_tx_req, 2) && $past(hdlc_tx_req)
    |-> !port_a_line_thirty_o_r) else $error("rts not low");
endmodule

/* verif/cmpp_far_model.sv */
// Purpose: far side of the port lines, phy or master
// Assumes: changes just after the falling edge
// Notes:   lines it does not own still toggle at random
`timescale 1ns/1ps
module cmpp_far_model (
  input  wire       clk_sys, // clock
  input  wire       rts_n,   // request line level
  output reg  [3:0] far_d,   // levels for lines 31..28
  output reg        cts_n    // clear to send
);
  reg [31:0] rnd;
  initial {far_d, cts_n} = 5'h1f;
  always @(negedge clk_sys) begin
    rnd = $urandom;
    far_d <= rnd[3:0];
    cts_n <= rts_n | rnd[4];
  end
endmodule

/* verif/cmpp_port_pins_tb_top.sv */
// Purpose: self-checking bench for cmpp_port_pins
// Assumes: inputs change on the falling edge
// Notes:   reference follows the inputs held at the last edge
`timescale 1ns/1ps
`include "cmpp_consts.vh"
module cmpp_port_pins_tb_top;
  reg clk_sys, reset, tx_valid, tx_first, tx_error, slv_can_take, rx_want, hdlc_tx_req, e, c;
  reg [2:0] mode;
  reg [3:0] phy_clav_hi;
  reg [1:0] phy_sel;
  reg [31:0] rnd;
  integer fails, n_tests, cyc, m, hst;
  reg [3:0] pa_q;
  reg [1:0] rxp, rts_p, gnt_p;
  wire cts_n, tx_take_r, rx_sample_r, slv_tx_en_r, slv_rx_en_r, mii_col_r, mii_crs_r;
  wire peer_clav_r, hdlc_grant_r;
  wire [3:0] phy_clav_r, far_d, po, oe_n;
  wire [3:0] pa_i = (po & ~oe_n) | (far_d & oe_n);
  cmpp_port_pins dut_u (.clk_sys, .reset, .mode, .tx_valid, .tx_first, .tx_error, .slv_can_take,
    .rx_want, .hdlc_tx_req, .hdlc_cts_n(cts_n), .phy_clav_hi, .phy_sel, .tx_take_r,
    .peer_clav_r, .phy_clav_r, .rx_sample_r, .slv_tx_en_r, .slv_rx_en_r, .mii_col_r,
    .mii_crs_r, .hdlc_grant_r, .port_a_line_thirty_one_i(pa_i[3]), .port_a_line_thirty_i(pa_i[2]), .port_a_line_twenty_nine_i(pa_i[1]),
    .port_a_line_twenty_eight_i(pa_i[0]), .port_a_line_thirty_one_o_r(po[3]), .port_a_line_thirty_o_r(po[2]), .port_a_line_twenty_nine_o_r(po[1]), .port_a_line_twenty_eight_o_r(po[0]),
    .port_a_line_thirty_one_oe_n_r(oe_n[3]), .port_a_line_thirty_oe_n_r(oe_n[2]), .port_a_line_twenty_nine_oe_n_r(oe_n[1]), .port_a_line_twenty_eight_oe_n_r(oe_n[0]));
  cmpp_far_model far_u (.clk_sys, .rts_n(pa_i[2]), .far_d, .cts_n);
  task chk(input logic [3:0] seen, input logic [3:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // line levels and two-stage reference pipes as seen at the rising edge
  always @(posedge clk_sys) begin
    pa_q <= pa_i;
    rxp <= {rxp[0], ((mode == 1 || mode == 3) && rx_want) || (mode == 2 && pa_i[0])};
    if (reset) begin
      hst = 0;
      rts_p <= 2'b01;
      gnt_p <= 2'b00;
    end else begin
      if (mode != 5 || !hdlc_tx_req) hst = 0;
      else if (hst == 0) hst = 1;
      else if (hst == 1 && !cts_n) hst = 2;
      rts_p <= {rts_p[0], hst == 0};
      gnt_p <= {gnt_p[0], hst == 2 && !cts_n};
    end
  end
  always @(negedge clk_sys) if (!reset) begin
    c = (mode == `CMPP_MODE_UT_MPHY && phy_sel != 2'h0) ? phy_clav_hi[phy_sel] : pa_q[2];
    e = tx_valid & c;
    case (mode)
      `CMPP_MODE_UT_MST, `CMPP_MODE_UT_MPHY: begin
        chk({po[3], po[1], po[0], tx_take_r},
          {e, e & tx_first, rx_want, e});
        chk({peer_clav_r, rx_sample_r}, {c, rxp[1]});
        if (mode == `CMPP_MODE_UT_MPHY) chk(phy_clav_r, {phy_clav_hi[3:1], pa_q[2]});
      end
      `CMPP_MODE_UT_SLV: chk({po[2], slv_tx_en_r, slv_rx_en_r, rx_sample_r},
        {slv_can_take, pa_q[3], pa_q[0], rxp[1]});
      `CMPP_MODE_MII: chk({po[1:0], mii_col_r, mii_crs_r}, {tx_error, tx_valid, pa_q[3:2]});
      `CMPP_MODE_HDLC: chk({po[2], hdlc_grant_r, mii_col_r, slv_tx_en_r},
        {rts_p[1], gnt_p[1], 2'b00});
      default: chk({mii_col_r, slv_tx_en_r}, 4'h0);
    endcase
    chk(oe_n, mode == 1 || mode == 3 ? 4'h4 : mode == 4 ? 4'hc : mode == 0 ? 4'hf : 4'hb);
  end
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      fails = fails + 1;
      summarize;
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    {reset, mode, tx_valid, tx_first, tx_error, slv_can_take, rx_want, hdlc_tx_req} = 10'h200;
    {phy_clav_hi, phy_sel, fails, n_tests, cyc} = 0;
    rnd = $urandom(32'hc318);
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys) reset <= 1'b0;
    for (m = 0; m < 6; m = m + 1) begin
      mode <= m[2:0];
      repeat (300) begin
        @(negedge clk_sys);
        rnd = $urandom;
        {tx_valid, tx_first, tx_error, slv_can_take, rx_want, hdlc_tx_req, phy_clav_hi} <= rnd[9:0];
        phy_sel <= (m == 3) ? rnd[11:10] : 2'h0;
      end
      $display("test mode %0d done", m);
    end
    summarize;
  end
endmodule
bind cmpp_port_pins cmpp_chk #(.PHY_NUM(PHY_NUM)) chk_u (.clk_sys, .reset, .mode, .tx_valid,
  .tx_first, .tx_error, .rx_want, .slv_can_take, .hdlc_tx_req, .port_a_line_thirty_one_i, .port_a_line_thirty_i, .phy_clav_hi,
  .phy_clav_r, .port_a_line_thirty_one_o_r, .port_a_line_thirty_o_r, .port_a_line_twenty_nine_o_r, .port_a_line_twenty_eight_o_r, .port_a_line_thirty_oe_n_r, .rx_sample_r, .mii_col_r);
